// ### verilog/ssp_pkg.sv
// Shared constants, field layouts and types for the synchronous serial audio port.
// Assumes byte addressing on a 32-bit Avalon-MM bus, one register per aligned word.
package ssp_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_DIVIDER   = 8'h04;
  localparam logic [7:0] REG_RX_CLKMOD = 8'h10;
  localparam logic [7:0] REG_RX_FRMMOD = 8'h14;
  localparam logic [7:0] REG_TX_CLKMOD = 8'h18;
  localparam logic [7:0] REG_TX_FRMMOD = 8'h1C;
  localparam logic [7:0] REG_RX_HOLD   = 8'h20;
  localparam logic [7:0] REG_TX_HOLD   = 8'h24;
  localparam logic [7:0] REG_RX_SYNC   = 8'h30;
  localparam logic [7:0] REG_TX_SYNC   = 8'h34;
  localparam logic [7:0] REG_RX_CMP    = 8'h38;
  localparam logic [7:0] REG_STATUS    = 8'h40;

  // Control bit positions
  localparam int CTRL_RX_EN  = 0;
  localparam int CTRL_RX_DIS = 1;
  localparam int CTRL_TX_EN  = 8;
  localparam int CTRL_TX_DIS = 9;

  // Status bit positions
  localparam int STAT_TX_FREE  = 0;
  localparam int STAT_TX_EMPTY = 1;
  localparam int STAT_RX_FULL  = 4;
  localparam int STAT_RX_OVR   = 5;
  localparam int STAT_TX_SYNC  = 10;
  localparam int STAT_RX_SYNC  = 11;
  localparam int STAT_RX_ON    = 16;
  localparam int STAT_TX_ON    = 17;

  // Reset values
  localparam logic [11:0] DIV_RESET  = 12'h000;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  // Side indices
  localparam int SIDE_RX = 0;
  localparam int SIDE_TX = 1;

  // Field encodings
  localparam logic [1:0] CLKSRC_DIV   = 2'h0;
  localparam logic [1:0] CLKSRC_OTHER = 2'h1;
  localparam logic [1:0] CLKSRC_PIN   = 2'h2;
  localparam logic [1:0] CLKOUT_NONE  = 2'h0;
  localparam logic [1:0] CLKOUT_CONT  = 2'h1;
  localparam logic [1:0] CLKOUT_XFER  = 2'h2;
  localparam logic [3:0] START_CONT   = 4'h0;
  localparam logic [3:0] START_OTHER  = 4'h1;
  localparam logic [3:0] START_LOW    = 4'h2;
  localparam logic [3:0] START_HIGH   = 4'h3;
  localparam logic [3:0] START_FALL   = 4'h4;
  localparam logic [3:0] START_RISE   = 4'h5;
  localparam logic [3:0] START_EDGE   = 4'h6;
  localparam logic [3:0] START_CMP    = 4'h7;
  localparam logic [2:0] FSOUT_INPUT  = 3'h0;
  localparam logic [2:0] FSOUT_NEG    = 3'h1;
  localparam logic [2:0] FSOUT_POS    = 3'h2;
  localparam logic [2:0] FSOUT_LOW    = 3'h3;
  localparam logic [2:0] FSOUT_HIGH   = 3'h4;
  localparam logic [2:0] FSOUT_TOGGLE = 3'h5;
  localparam logic [4:0] SYNC_MAX     = 5'h10;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_DELAY = 2'b10,
    ST_DATA  = 2'b11
  } ssp_state_e;

  typedef struct packed {
    logic [7:0] period;
    logic [7:0] start_delay;
    logic [3:0] rsv_a;
    logic [3:0] start_select;
    logic [2:0] rsv_b;
    logic       clock_invert;
    logic [1:0] clock_output_mode;
    logic [1:0] clock_source_select;
  } ssp_cmode_s;

  typedef struct packed {
    logic [3:0] frame_sync_length_hi;
    logic [2:0] rsv_a;
    logic       sync_edge_select;
    logic       sync_data_enable;
    logic [2:0] frame_sync_output_select;
    logic [3:0] frame_sync_length;
    logic [3:0] rsv_b;
    logic [3:0] word_count;
    logic       msb_first;
    logic [1:0] rsv_c;
    logic [4:0] word_length;
  } ssp_fmode_s;

endpackage

// ### verilog/ssp_top.sv
// Synchronous serial audio port: divider, receiver, transmitter, Avalon-MM registers.
// Assumes clk_sys is the master clock; pin clocks are far slower and sampled here.
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module ssp_top (
  // System
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  // Receive pins
  input  wire logic        receive_clock_pin_in,
  output      logic        receive_clock_pin_out,
  output      logic        receive_clock_pin_oe,
  input  wire logic        receive_frame_pin_in,
  output      logic        receive_frame_pin_out,
  output      logic        receive_frame_pin_oe,
  input  wire logic        receive_data_pin,
  // Transmit pins
  input  wire logic        transmit_clock_pin_in,
  output      logic        transmit_clock_pin_out,
  output      logic        transmit_clock_pin_oe,
  input  wire logic        transmit_frame_pin_in,
  output      logic        transmit_frame_pin_out,
  output      logic        transmit_frame_pin_oe,
  output      logic        transmit_data_pin
);

  localparam int RX = ssp_pkg::SIDE_RX;
  localparam int TX = ssp_pkg::SIDE_TX;

  logic [11:0]         div, next_div;
  ssp_pkg::ssp_cmode_s cm [2], next_cm [2];
  ssp_pkg::ssp_fmode_s fm [2], next_fm [2];
  logic [1:0]          en, next_en, syn, next_syn;
  logic [31:0]         thr, next_thr, receive_holding_register, next_rhr, rdata, next_rdata;
  logic [15:0]         tsh, next_tsh, rsh, next_rsh, rc0, next_rc0;
  logic                thr_full, next_thr_full, rx_full, next_rx_full;
  logic                ovr, next_ovr, ack, next_ack, rhr_fresh;
  logic                req, acc, wr, rd_rhr;
  logic [31:0]         bmask, wdm, stat;
  logic [11:0]         dcnt, next_dcnt;
  logic                dclk, next_dclk;
  logic [4:0]          sy1, sy2, sy3, filt, next_filt;
  logic [1:0]          base, clk_sel, ev_load, ev_done, in_data, in_xfer, syn_ev;
  logic [1:0]          fs_out_v, fs_oe_v, ck_oe_v;
  logic [31:0]         rx_word;
  logic [15:0]         rx_sync;
  logic                rx_sync_done, cmp_hit, txd;

  // Bus slave: one wait cycle, then the request is taken
  assign req             = avs_read || avs_write;
  assign acc             = req && ack && ce;
  assign wr              = acc && avs_write;
  assign rd_rhr          = acc && avs_read && avs_address == ssp_pkg::REG_RX_HOLD;
  assign avs_waitrequest = req && !(ack && ce);
  assign avs_readdata    = rdata;
  assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdm   = avs_writedata & bmask;

  always_comb begin
    stat = 32'h0000_0000;
    stat[ssp_pkg::STAT_TX_FREE]  = !thr_full;
    stat[ssp_pkg::STAT_TX_EMPTY] = !thr_full && !in_data[TX];
    stat[ssp_pkg::STAT_RX_FULL]  = rx_full;
    stat[ssp_pkg::STAT_RX_OVR]   = ovr;
    stat[ssp_pkg::STAT_TX_SYNC]  = syn[TX];
    stat[ssp_pkg::STAT_RX_SYNC]  = syn[RX];
    stat[ssp_pkg::STAT_RX_ON]    = en[RX];
    stat[ssp_pkg::STAT_TX_ON]    = en[TX];
  end

  always_comb begin
    next_div = div;  next_cm = cm;  next_fm = fm;  next_en = en;  next_thr = thr;
    next_tsh = tsh;  next_rc0 = rc0;  next_rhr = receive_holding_register;  next_rsh = rsh;
    next_thr_full = thr_full;  next_rx_full = rx_full;  next_ovr = ovr;  next_syn = syn;
    next_ack = req && !ack;
    next_rdata = rdata;
    if (req && !ack) begin
      unique case (avs_address)
        ssp_pkg::REG_DIVIDER:   next_rdata = {20'h00000, div};
        ssp_pkg::REG_RX_CLKMOD: next_rdata = cm[RX];
        ssp_pkg::REG_RX_FRMMOD: next_rdata = fm[RX];
        ssp_pkg::REG_TX_CLKMOD: next_rdata = cm[TX];
        ssp_pkg::REG_TX_FRMMOD: next_rdata = fm[TX];
        ssp_pkg::REG_RX_HOLD:   next_rdata = receive_holding_register;
        ssp_pkg::REG_RX_SYNC:   next_rdata = {16'h0000, rsh};
        ssp_pkg::REG_TX_SYNC:   next_rdata = {16'h0000, tsh};
        ssp_pkg::REG_RX_CMP:    next_rdata = {16'h0000, rc0};
        ssp_pkg::REG_STATUS:    next_rdata = stat;
        default:                next_rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (avs_address)
        ssp_pkg::REG_CTRL: begin
          if (wdm[ssp_pkg::CTRL_RX_EN])  next_en[RX] = 1'b1;
          if (wdm[ssp_pkg::CTRL_RX_DIS]) next_en[RX] = 1'b0;
          if (wdm[ssp_pkg::CTRL_TX_EN])  next_en[TX] = 1'b1;
          if (wdm[ssp_pkg::CTRL_TX_DIS]) next_en[TX] = 1'b0;
        end
        ssp_pkg::REG_DIVIDER:   next_div = (div & ~bmask[11:0]) | wdm[11:0];
        ssp_pkg::REG_RX_CLKMOD: next_cm[RX] = (cm[RX] & ~bmask) | wdm;
        ssp_pkg::REG_RX_FRMMOD: next_fm[RX] = (fm[RX] & ~bmask) | wdm;
        ssp_pkg::REG_TX_CLKMOD: next_cm[TX] = (cm[TX] & ~bmask) | wdm;
        ssp_pkg::REG_TX_FRMMOD: next_fm[TX] = (fm[TX] & ~bmask) | wdm;
        ssp_pkg::REG_TX_HOLD:   next_thr = (thr & ~bmask) | wdm;
        ssp_pkg::REG_TX_SYNC:   next_tsh = (tsh & ~bmask[15:0]) | wdm[15:0];
        ssp_pkg::REG_RX_CMP:    next_rc0 = (rc0 & ~bmask[15:0]) | wdm[15:0];
        default:                next_div = div;
      endcase
    end
    // read empties, write fills
    // A word that landed after the read snapshot stays full
    if (rd_rhr && !rhr_fresh) next_rx_full = 1'b0;
    if (acc && avs_read && avs_address == ssp_pkg::REG_STATUS) begin
      // Clear only what the snapshot reported, so a fresh set survives
      next_ovr = ovr && !rdata[ssp_pkg::STAT_RX_OVR];
      next_syn = syn & ~{rdata[ssp_pkg::STAT_TX_SYNC], rdata[ssp_pkg::STAT_RX_SYNC]};
    end
    if (ev_load[TX]) next_thr_full = 1'b0;
    if (wr && avs_address == ssp_pkg::REG_TX_HOLD) next_thr_full = 1'b1;
    if (ev_done[RX]) begin
      next_rhr = rx_word;
      next_rx_full = 1'b1;
      if (rx_full && !rd_rhr) next_ovr = 1'b1;
    end
    if (rx_sync_done) next_rsh = rx_sync;
    next_syn = next_syn | syn_ev;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div <= ssp_pkg::DIV_RESET;
      cm[RX] <= ssp_pkg::MODE_RESET;
      cm[TX] <= ssp_pkg::MODE_RESET;
      fm[RX] <= ssp_pkg::MODE_RESET;
      fm[TX] <= ssp_pkg::MODE_RESET;
      en <= 2'b00;  syn <= 2'b00;  thr <= 32'h0000_0000;  receive_holding_register <= 32'h0000_0000;
      rdata <= 32'h0000_0000;  tsh <= 16'h0000;  rsh <= 16'h0000;  rc0 <= 16'h0000;
      thr_full <= 1'b0;  rx_full <= 1'b0;  ovr <= 1'b0;  ack <= 1'b0;
      rhr_fresh <= 1'b0;
    end else if (ce) begin
      div <= next_div;  cm <= next_cm;  fm <= next_fm;  en <= next_en;  syn <= next_syn;
      thr <= next_thr;  receive_holding_register <= next_rhr;  rdata <= next_rdata;  tsh <= next_tsh;
      rsh <= next_rsh;  rc0 <= next_rc0;  thr_full <= next_thr_full;
      rx_full <= next_rx_full;  ovr <= next_ovr;  ack <= next_ack;
      rhr_fresh <= ev_done[RX];
    end
  end

  // Pin synchronisers: a change counts once stages two and three agree
  always_comb begin
    next_filt = (sy2 & sy3) | (filt & (sy2 ^ sy3));
    next_dclk = 1'b0;
    next_dcnt = 12'h000;
    if (div != 12'h000) begin
      next_dclk = dclk;
      next_dcnt = dcnt + 12'h001;
      if (dcnt >= div - 12'h001) begin
        next_dcnt = 12'h000;
        next_dclk = !dclk;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sy1 <= 5'h00;  sy2 <= 5'h00;  sy3 <= 5'h00;  filt <= 5'h00;
      dcnt <= 12'h000;  dclk <= 1'b0;
    end else if (ce) begin
      sy1 <= {receive_data_pin, transmit_frame_pin_in, receive_frame_pin_in,
              transmit_clock_pin_in, receive_clock_pin_in};
      sy2 <= sy1;  sy3 <= sy2;  filt <= next_filt;
      dcnt <= next_dcnt;  dclk <= next_dclk;
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_side
    localparam int O = 1 - s;
    ssp_pkg::ssp_state_e st, next_st;
    logic [7:0] cnt, next_cnt;
    logic [3:0] wn, next_wn;
    logic [31:0] sh, next_sh, wmask;
    logic [15:0] ssh, next_ssh;
    logic [8:0] pc, next_pc, fsc, next_fsc, plen;
    logic tg, next_tg, fso, next_fso, icp, fsp, fslp, fsl;
    logic iclk, ben, sev, trig, sync_on, word_go;
    logic [5:0] wlen;
    logic [4:0] slen;

    assign base[s]    = (cm[s].clock_source_select == ssp_pkg::CLKSRC_PIN) ? filt[s] : dclk;
    assign clk_sel[s] = (cm[s].clock_source_select == ssp_pkg::CLKSRC_OTHER) ? base[O] : base[s];
    assign iclk = clk_sel[s] ^ cm[s].clock_invert;
    assign ben  = ce && ((s == RX) ? (iclk && !icp) : (!iclk && icp));
    assign fsl  = fs_oe_v[s] ? fso : filt[2 + s];
    assign wlen = {1'b0, fm[s].word_length} + 6'h01;
    assign wmask = ~(32'hFFFF_FFFF << wlen);
    assign plen = {1'b0, fm[s].frame_sync_length_hi, fm[s].frame_sync_length} + 9'h001;
    assign slen = (plen > {4'h0, ssp_pkg::SYNC_MAX}) ? ssp_pkg::SYNC_MAX : plen[4:0];
    assign sync_on = (s == RX) || (fm[s].sync_data_enable
                     && cm[s].start_select != ssp_pkg::START_CONT);
    assign trig = ben && ((cm[s].period != 8'h00) ? (pc == 9'h000)
                                                  : (st == ssp_pkg::ST_WAIT && sev));
    assign in_data[s] = st == ssp_pkg::ST_DATA;
    assign in_xfer[s] = st == ssp_pkg::ST_DATA || st == ssp_pkg::ST_DELAY;
    assign fs_out_v[s] = fso;
    assign fs_oe_v[s]  = fm[s].frame_sync_output_select != ssp_pkg::FSOUT_INPUT;
    assign ck_oe_v[s] = cm[s].clock_output_mode == ssp_pkg::CLKOUT_CONT
                     || (cm[s].clock_output_mode == ssp_pkg::CLKOUT_XFER && in_xfer[s]);
    assign syn_ev[s] = ce && (fm[s].sync_edge_select ? (fslp && !fsl) : (!fslp && fsl));

    always_comb begin
      unique case (cm[s].start_select)
        ssp_pkg::START_CONT:  sev = (s == TX) ? thr_full : 1'b1;
        ssp_pkg::START_OTHER: sev = in_xfer[O];
        ssp_pkg::START_LOW:   sev = !fsl;
        ssp_pkg::START_HIGH:  sev = fsl;
        ssp_pkg::START_FALL:  sev = fsp && !fsl;
        ssp_pkg::START_RISE:  sev = !fsp && fsl;
        ssp_pkg::START_EDGE:  sev = fsp != fsl;
        ssp_pkg::START_CMP:   sev = (s == RX) && cmp_hit;
        default:              sev = 1'b0;
      endcase
    end

    always_comb begin
      next_st = st;  next_cnt = cnt;  next_wn = wn;  next_sh = sh;  next_ssh = ssh;
      next_pc = pc;  next_fsc = fsc;  next_tg = tg;  word_go = 1'b0;
      ev_load[s] = 1'b0;
      ev_done[s] = 1'b0;
      if (!en[s]) begin
        next_st = ssp_pkg::ST_IDLE;
      end else if (ben) begin
        unique case (st)
          ssp_pkg::ST_IDLE: next_st = ssp_pkg::ST_WAIT;
          ssp_pkg::ST_WAIT: if (sev) begin
            next_cnt = 8'h00;
            next_wn  = 4'h0;
            next_st  = (cm[s].start_delay == 8'h00) ? ssp_pkg::ST_DATA : ssp_pkg::ST_DELAY;
            word_go  = cm[s].start_delay == 8'h00;
          end
          ssp_pkg::ST_DELAY: begin
            if (s == RX && {3'h0, slen} > cnt) next_ssh = {ssh[14:0], filt[4]};
            next_cnt = cnt + 8'h01;
            if (cnt >= cm[s].start_delay - 8'h01) begin
              next_st  = ssp_pkg::ST_DATA;
              next_cnt = 8'h00;
              word_go  = 1'b1;
            end
          end
          ssp_pkg::ST_DATA: begin
            if (s == RX) begin
              next_sh = fm[s].msb_first ? {sh[30:0], filt[4]} : {filt[4], sh[31:1]};
            end
            next_cnt = cnt + 8'h01;
            if (cnt == {2'b00, wlen - 6'h01}) begin
              ev_done[s] = 1'b1;
              next_cnt = 8'h00;
              if (wn == fm[s].word_count) begin
                next_st = ssp_pkg::ST_WAIT;
              end else begin
                next_wn = wn + 4'h1;
                word_go = 1'b1;
              end
            end
          end
        endcase
        if (word_go && s == TX) begin
          next_sh = thr_full ? thr : 32'h0000_0000;
          ev_load[s] = thr_full;
        end
        if (cm[s].period != 8'h00) next_pc = (pc == 9'h000) ? {cm[s].period, 1'b1} : pc - 9'h001;
        if (trig) begin
          next_fsc = plen;
          next_tg  = !tg;
        end else if (fsc != 9'h000) begin
          next_fsc = fsc - 9'h001;
        end
      end
      unique case (fm[s].frame_sync_output_select)
        ssp_pkg::FSOUT_INPUT:  next_fso = fso;
        ssp_pkg::FSOUT_NEG:    next_fso = next_fsc == 9'h000;
        ssp_pkg::FSOUT_POS:    next_fso = next_fsc != 9'h000;
        ssp_pkg::FSOUT_LOW:    next_fso = next_st != ssp_pkg::ST_DATA;
        ssp_pkg::FSOUT_HIGH:   next_fso = next_st == ssp_pkg::ST_DATA;
        ssp_pkg::FSOUT_TOGGLE: next_fso = next_tg;
        default:               next_fso = 1'b0;
      endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        st <= ssp_pkg::ST_IDLE;  cnt <= 8'h00;  wn <= 4'h0;  sh <= 32'h0000_0000;
        ssh <= 16'h0000;  pc <= 9'h000;  fsc <= 9'h000;  tg <= 1'b0;  fso <= 1'b0;
        icp <= 1'b0;  fsp <= 1'b0;  fslp <= 1'b0;
      end else if (ce) begin
        st <= next_st;  cnt <= next_cnt;  wn <= next_wn;  sh <= next_sh;  ssh <= next_ssh;
        pc <= next_pc;  fsc <= next_fsc;  tg <= next_tg;  fso <= next_fso;
        icp <= iclk;  fslp <= fsl;
        if (ben) fsp <= fsl;
      end
    end

    if (s == RX) begin : g_rx
      logic [15:0] hist, smask;
      assign smask = ~(16'hFFFF << slen);
      assign cmp_hit = ((hist ^ rc0) & smask) == 16'h0000;
      assign rx_word = fm[s].msb_first ? (next_sh & wmask) : (next_sh >> (6'h20 - wlen));
      // Sync word ends when the last sync bit lands
      assign rx_sync = next_ssh & smask;
      assign rx_sync_done = ben && st == ssp_pkg::ST_DELAY && {3'h0, slen} == cnt + 8'h01;
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) hist <= 16'h0000;
        else if (ben) hist <= {hist[14:0], filt[4]};
      end
    end else begin : g_tx
      logic [4:0] didx, sidx;
      logic       next_txd;
      assign didx = fm[s].msb_first ? (wlen[4:0] - 5'h01 - next_cnt[4:0]) : next_cnt[4:0];
      assign sidx = slen - 5'h01 - next_cnt[4:0];
      always_comb begin
        next_txd = 1'b0;
        if (next_st == ssp_pkg::ST_DATA) next_txd = next_sh[didx];
        else if (next_st == ssp_pkg::ST_DELAY && sync_on && {3'h0, slen} > next_cnt)
          next_txd = tsh[sidx[3:0]];
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) txd <= 1'b0;
        else if (ben) txd <= next_txd;
      end
    end
  end

  assign receive_clock_pin_out  = clk_sel[RX];
  assign receive_clock_pin_oe   = ck_oe_v[RX];
  assign transmit_clock_pin_out = clk_sel[TX];
  assign transmit_clock_pin_oe  = ck_oe_v[TX];
  assign receive_frame_pin_out  = fs_out_v[RX];
  assign receive_frame_pin_oe   = fs_oe_v[RX];
  assign transmit_frame_pin_out = fs_out_v[TX];
  assign transmit_frame_pin_oe  = fs_oe_v[TX];
  assign transmit_data_pin      = txd;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  div_off_a: assert property (ce && div == 12'h000 |=> !dclk)
    else $error("divided clock moves with factor zero");
  div_phase_a: assert property ((ce && div == 12'h003 && $rose(dclk)) ##1
    (ce && div == 12'h003) ##1 (ce && div == 12'h003) |=> $fell(dclk))
    else $error("divided clock phase length wrong");
  tx_free_a: assert property (ev_load[TX] && !wr |=> !thr_full && stat[0])
    else $error("holding free flag not set after load");
  rx_full_a: assert property (ev_done[RX] |=> rx_full && receive_holding_register == $past(rx_word))
    else $error("received word not held");
  rx_ovr_a: assert property (ev_done[RX] && rx_full && !rd_rhr |=> ovr)
    else $error("overrun flag missed");
  rx_clear_a: assert property (rd_rhr && !ev_done[RX] && !rhr_fresh |=> !rx_full)
    else $error("full flag stays after read");
  fs_low_a: assert property (fm[TX].frame_sync_output_select == ssp_pkg::FSOUT_LOW
    && $past(fm[TX].frame_sync_output_select) == ssp_pkg::FSOUT_LOW
    |-> transmit_frame_pin_out == !in_data[TX])
    else $error("frame pin not low during data");
  fs_len_a: assert property (g_side[TX].trig |=> g_side[TX].fsc == $past(g_side[TX].plen))
    else $error("pulse length not loaded");
  sync_flag_a: assert property (syn_ev[RX] |=> syn[RX])
    else $error("sync edge flag missed");

endmodule // ssp_top

// ### verif/ssp_codec_model.sv
// Codec-side model: echoes serial data back and drives both frame lines on command.
// Assumes the port masters the bit clocks; frame levels resolve from the port's enables.
`timescale 1ns/1ps
module ssp_codec_model (
  // From the port
  input  wire logic tx_data,
  input  wire logic tx_frm_out,
  input  wire logic tx_frm_oe,
  input  wire logic rx_frm_out,
  input  wire logic rx_frm_oe,
  // From the bench
  input  wire logic frm_cmd,
  // To the port
  output      logic rx_data,
  output      logic rx_frm,
  output      logic tx_frm
);
  // no codec clock
  // The port supplies every bit clock, so no pin clock can run too fast
  assign rx_data = tx_data;
  assign rx_frm  = rx_frm_oe ? rx_frm_out : frm_cmd;
  assign tx_frm  = tx_frm_oe ? tx_frm_out : frm_cmd;
endmodule // ssp_codec_model

// ### verif/ssp_top_tb.sv
// Bench for the serial audio port: divider, looped word traffic, flags, sync edge.
// Assumes the codec model echoes transmit data; unused pin clocks rest low.
`timescale 1ns/1ps
module ssp_top_tb;
  logic        clk_sys, rst, avs_read, avs_write, frm_cmd;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        avs_waitrequest, rko, rke, tko, tke, rfo, rfe, tfo, tfe, td, rd, rf, tf;
  int          error_cnt, n_tests, c;

  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end

  ssp_top dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .receive_clock_pin_in(rke ? rko : 1'b0), .receive_clock_pin_out(rko),
    .receive_clock_pin_oe(rke), .receive_frame_pin_in(rf), .receive_frame_pin_out(rfo),
    .receive_frame_pin_oe(rfe), .receive_data_pin(rd),
    .transmit_clock_pin_in(tke ? tko : 1'b0), .transmit_clock_pin_out(tko),
    .transmit_clock_pin_oe(tke), .transmit_frame_pin_in(tf), .transmit_frame_pin_out(tfo),
    .transmit_frame_pin_oe(tfe), .transmit_data_pin(td));

  ssp_codec_model partner (.tx_data(td), .tx_frm_out(tfo), .tx_frm_oe(tfe), .rx_frm_out(rfo),
    .rx_frm_oe(rfe), .frm_cmd(frm_cmd), .rx_data(rd), .rx_frm(rf), .tx_frm(tf));

  task close_out;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // Avalon cycle: held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        close_out();
      end
      @(posedge clk_sys);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Length of one whole phase of the receive clock pin; 50 means it never moved
  task phase(output int cnt);
    logic p;
    int   n;
    p = rko;
    n = 0;
    while (rko === p && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    p = rko;
    cnt = 0;
    while (rko === p && cnt < 50) begin
      @(posedge clk_sys);
      cnt++;
    end
  endtask

  task poll(input int b);
    int n;
    n = 0;
    do begin
      bus(0, ssp_pkg::REG_STATUS, 0);
      n++;
    end while (q[b] !== 1'b1 && n < 200);
    if (q[b] !== 1'b1) begin
      error_cnt++;
      close_out();
    end
  endtask

  initial begin
    rst = 1;
    {avs_read, avs_write, avs_address, avs_writedata, frm_cmd} = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    bus(1, ssp_pkg::REG_RX_CLKMOD, 32'h0000_0004);
    phase(c);
    chk(32'(c), 32'h32, "divider ran at zero");
    chk({31'h0, rke}, 32'h1, "clock pin not driven");
    bus(1, ssp_pkg::REG_DIVIDER, 32'h0000_0003);
    bus(1, ssp_pkg::REG_RX_CLKMOD, 32'h0000_0014);
    phase(c);
    chk(32'(c), 32'h3, "divided phase length");
    $display("divider test done");
    // Divided clocks only, so no pin source meets continuous output.
    // Receiver starts half a bit after the transmitter, on the next rising edge, so one delay bit leads.
    bus(1, ssp_pkg::REG_DIVIDER, 32'h0000_0008);
    bus(1, ssp_pkg::REG_TX_CLKMOD, 32'h0001_0008);
    bus(1, ssp_pkg::REG_RX_CLKMOD, 32'h0000_0100);
    bus(1, ssp_pkg::REG_TX_FRMMOD, 32'h0030_0087);
    bus(1, ssp_pkg::REG_RX_FRMMOD, 32'h0000_0087);
    bus(1, ssp_pkg::REG_CTRL, 32'h0000_0101);
    bus(1, ssp_pkg::REG_TX_HOLD, 32'h0000_00A5);
    poll(ssp_pkg::STAT_RX_FULL);
    bus(0, ssp_pkg::REG_RX_HOLD, 0);
    chk(q, 32'h0000_00A5, "received word");
    bus(0, ssp_pkg::REG_STATUS, 0);
    chk(q & 32'h10, 32'h0, "full after read");
    bus(1, ssp_pkg::REG_TX_HOLD, 32'h0000_003C);
    poll(ssp_pkg::STAT_TX_FREE);
    chk({31'h0, tke}, 32'h1, "transmit clock pin off in transfer");
    bus(1, ssp_pkg::REG_TX_HOLD, 32'h0000_0096);
    bus(0, ssp_pkg::REG_STATUS, 0);
    chk(q & 32'h1, 32'h0, "free after write");
    repeat (400) @(posedge clk_sys);
    bus(0, ssp_pkg::REG_STATUS, 0);
    chk(q & 32'h33, 32'h33, "flags after two words");
    chk({29'h0, tke, tfe, tfo}, 32'h3, "transmit pins after transfer");
    bus(0, ssp_pkg::REG_RX_HOLD, 0);
    chk(q, 32'h0000_0096, "overwritten word");
    $display("traffic test done");
    // Frame line back to input so the codec edge reaches it
    bus(1, ssp_pkg::REG_TX_FRMMOD, 32'h0000_0087);
    bus(0, ssp_pkg::REG_STATUS, 0);
    frm_cmd <= 1'b1;
    repeat (10) @(posedge clk_sys);
    bus(0, ssp_pkg::REG_STATUS, 0);
    chk(q & 32'h400, 32'h400, "sync edge flag");
    bus(0, ssp_pkg::REG_STATUS, 0);
    chk(q & 32'h400, 32'h0, "sync flag after read");
    $display("sync test done");
    close_out();
  end
endmodule // ssp_top_tb
